// ---- rtl/idc_decoder.sv ----
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module idc_decoder
    import idc_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // decoded instruction to datapath
    output idc_dec_t         DEC_OUT,
    output logic             EXEC_BUSY,
    output logic             CYCLE_END,
    output logic             PRESCALER_CLR
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic idc_dec_t decode(input logic [13:0] w, input logic [7:0] opnd);
        idc_dec_t d;
        d = '0;
        d.op        = OP_NO_OPERATION;
        d.dest_file = w[7];
        d.file_addr = w[6:0];
        d.bit_num   = w[9:7];
        d.literal   = w[7:0];
        d.target    = w[10:0];
        unique case (w[13:12])
            2'b00: begin
                d.file_read   = 1'b1;
                d.writes_file = w[7];
                unique case (w[11:8])
                    4'b0111: begin
                        d.op = OP_ADD_ACC_FILE;
                        {d.flag_c, d.flag_dc, d.flag_z} = 3'b111;
                    end
                    4'b0010: begin
                        d.op = OP_SUBTRACT_ACC_FROM_FILE;
                        {d.flag_c, d.flag_dc, d.flag_z} = 3'b111;
                    end
                    4'b0101: begin
                        d.op = OP_AND_ACC_FILE;
                        d.flag_z = 1'b1;
                    end
                    4'b0100: begin
                        d.op = OP_OR_ACC_FILE;
                        d.flag_z = 1'b1;
                    end
                    4'b0110: begin
                        d.op = OP_XOR_ACC_FILE;
                        d.flag_z = 1'b1;
                    end
                    4'b1101: begin
                        d.op = OP_ROTATE_LEFT_CARRY;
                        d.flag_c = 1'b1;
                    end
                    4'b1100: begin
                        d.op = OP_ROTATE_RIGHT_CARRY;
                        d.flag_c = 1'b1;
                    end
                    4'b1001: begin
                        d.op = OP_COMPLEMENT_FILE;
                        d.flag_z = 1'b1;
                    end
                    4'b0011: begin
                        d.op = OP_DECREMENT_FILE;
                        d.flag_z = 1'b1;
                    end
                    4'b1010: begin
                        d.op = OP_INCREMENT_FILE;
                        d.flag_z = 1'b1;
                    end
                    4'b1000: begin
                        d.op = OP_MOVE_FILE;
                        d.flag_z = 1'b1;
                    end
                    4'b1110: d.op = OP_SWAP_NIBBLES;
                    4'b1011: begin
                        d.op   = OP_DECREMENT_SKIP_ZERO;
                        d.skip = (opnd == 8'h01);
                    end
                    4'b1111: begin
                        d.op   = OP_INCREMENT_SKIP_ZERO;
                        d.skip = (opnd == 8'hff);
                    end
                    4'b0001: begin
                        d.flag_z    = 1'b1;
                        d.op        = w[7] ? OP_CLEAR_FILE : OP_CLEAR_ACC;
                        d.file_read = w[7];
                    end
                    4'b0000: begin
                        if (w[7]) begin
                            d.op = OP_STORE_ACC_TO_FILE;
                        end else begin
                            // control words carry no file address
                            d.file_read = 1'b0;
                            if (w[6:0] == 7'h08) begin
                                d.op        = OP_RETURN;
                                d.two_cycle = 1'b1;
                            end else if (w[6:0] == 7'h09) begin
                                d.op        = OP_INTERRUPT_RETURN;
                                d.two_cycle = 1'b1;
                            end else if (w[6:0] == 7'h63) begin
                                d.op        = OP_STANDBY;
                                d.flag_topd = 1'b1;
                            end else if (w[6:0] == 7'h64) begin
                                d.op        = OP_WATCHDOG_CLEAR;
                                d.flag_topd = 1'b1;
                            end else begin
                                d.op = OP_NO_OPERATION;
                            end
                        end
                    end
                endcase
                if (d.op == OP_NO_OPERATION || d.op == OP_CLEAR_ACC) begin
                    d.writes_file = 1'b0;
                end
            end
            2'b01: begin
                d.dest_file = 1'b1;
                d.file_read = 1'b1;
                unique case (w[11:10])
                    2'b00: begin
                        d.op          = OP_BIT_CLEAR;
                        d.writes_file = 1'b1;
                    end
                    2'b01: begin
                        d.op          = OP_BIT_SET;
                        d.writes_file = 1'b1;
                    end
                    2'b10: begin
                        d.op   = OP_TEST_SKIP_IF_CLEAR;
                        d.skip = ~opnd[w[9:7]];
                    end
                    2'b11: begin
                        d.op   = OP_TEST_SKIP_IF_SET;
                        d.skip = opnd[w[9:7]];
                    end
                endcase
            end
            2'b10: begin
                d.op        = w[11] ? OP_JUMP : OP_CALL;
                d.two_cycle = 1'b1;
            end
            2'b11: begin
                casez (w[11:8])
                    4'b00??: d.op = OP_LOAD_LITERAL;
                    4'b01??: begin
                        d.op        = OP_RETURN_WITH_LITERAL;
                        d.two_cycle = 1'b1;
                    end
                    4'b1000: begin
                        d.op = OP_OR_LITERAL;
                        d.flag_z = 1'b1;
                    end
                    4'b1001: begin
                        d.op = OP_AND_LITERAL;
                        d.flag_z = 1'b1;
                    end
                    4'b1010: begin
                        d.op = OP_XOR_LITERAL;
                        d.flag_z = 1'b1;
                    end
                    4'b110?: begin
                        d.op = OP_LITERAL_MINUS_ACC;
                        {d.flag_c, d.flag_dc, d.flag_z} = 3'b111;
                    end
                    4'b111?: begin
                        d.op = OP_ADD_LITERAL;
                        {d.flag_c, d.flag_dc, d.flag_z} = 3'b111;
                    end
                    default: d.op = OP_NO_OPERATION;
                endcase
            end
        endcase
        d.two_cycle = d.two_cycle | d.skip;
        return d;
    endfunction

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [13:0] instr_reg;
    logic [7:0]  file_val_reg;
    logic [7:0]  pin_val_reg;
    logic [16:0] ctrl_reg;
    idc_seq_t    seq_reg;
    logic [1:0]  phase_reg;
    logic        wb_req;
    logic        wr_instr;
    logic [13:0] instr_in;
    logic        is_port;
    logic [7:0]  operand;
    idc_dec_t    dec_next;
    logic        tmr_write;

    assign wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    // instruction writes while busy are dropped so the latched decode stays stable
    assign wr_instr = wb_req & WB_WE_I & (WB_ADR_I == IDC_OFS_INSTR) & WB_SEL_I[0] & (seq_reg == SEQ_IDLE);

    // port match must use the word being written, not the previous one
    assign instr_in = WB_SEL_I[1] ? WB_DAT_I[13:0] : {instr_reg[13:8], WB_DAT_I[7:0]};
    assign is_port  = (instr_in[6:0] == ctrl_reg[IDC_CTRL_PORT_LSB +: 7]);
    // port reads see the pins, not the output latch
    assign operand  = is_port ? pin_val_reg : file_val_reg;

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            instr_reg    <= IDC_INSTR_RST;
            file_val_reg <= IDC_BYTE_RST;
            pin_val_reg  <= IDC_BYTE_RST;
            ctrl_reg     <= IDC_CTRL_RST;
        end else if (wb_req && WB_WE_I) begin
            if (wr_instr)
                instr_reg <= instr_in;
            if (WB_ADR_I == IDC_OFS_FILE && WB_SEL_I[0])
                file_val_reg <= WB_DAT_I[7:0];
            if (WB_ADR_I == IDC_OFS_PINS && WB_SEL_I[0])
                pin_val_reg <= WB_DAT_I[7:0];
            if (WB_ADR_I == IDC_OFS_CTRL && WB_SEL_I[0])
                ctrl_reg[7:0] <= WB_DAT_I[7:0];
            if (WB_ADR_I == IDC_OFS_CTRL && WB_SEL_I[1])
                ctrl_reg[15:8] <= WB_DAT_I[15:8];
            if (WB_ADR_I == IDC_OFS_CTRL && WB_SEL_I[2])
                ctrl_reg[16] <= WB_DAT_I[16];
        end
    end

    // ------------------------------------------------------------
    // wishbone answer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= 32'h0000_0000;
            if (wb_req && !WB_WE_I) begin
                unique case (WB_ADR_I)
                    IDC_OFS_INSTR:  WB_DAT_O <= {18'h0_0000, instr_reg};
                    IDC_OFS_FILE:   WB_DAT_O <= {24'h00_0000, file_val_reg};
                    IDC_OFS_PINS:   WB_DAT_O <= {24'h00_0000, pin_val_reg};
                    IDC_OFS_CTRL:   WB_DAT_O <= {15'h0000, ctrl_reg};
                    IDC_OFS_DEC_A: begin
                        WB_DAT_O[7:0]                    <= DEC_OUT.literal;
                        WB_DAT_O[IDC_DECA_FILE_LSB +: 7] <= DEC_OUT.file_addr;
                        WB_DAT_O[IDC_DECA_DEST_BIT]      <= DEC_OUT.dest_file;
                        WB_DAT_O[IDC_DECA_BIT_LSB +: 3]  <= DEC_OUT.bit_num;
                        WB_DAT_O[IDC_DECA_OP_LSB +: 6]   <= DEC_OUT.op;
                    end
                    IDC_OFS_DEC_B: begin
                        WB_DAT_O[10:0]                  <= DEC_OUT.target;
                        WB_DAT_O[IDC_DECB_FLG_LSB +: 9] <= {DEC_OUT.writes_file, DEC_OUT.use_pins,
                                                            DEC_OUT.file_read, DEC_OUT.skip,
                                                            DEC_OUT.two_cycle, DEC_OUT.flag_topd,
                                                            DEC_OUT.flag_z, DEC_OUT.flag_dc,
                                                            DEC_OUT.flag_c};
                    end
                    IDC_OFS_STATUS: WB_DAT_O <= {28'h000_0000, phase_reg,
                                                 seq_reg == SEQ_SECOND, EXEC_BUSY};
                    default:        WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // decode latch
    // ------------------------------------------------------------
    always_comb begin
        dec_next          = decode(instr_in, operand);
        // any instruction that reads the file at the port address picks the pins
        dec_next.use_pins = dec_next.file_read & is_port;
    end

    // operand is judged against the address being written this cycle
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            DEC_OUT <= '0;
        end else if (wr_instr) begin
            DEC_OUT <= dec_next;
        end
    end

    // ------------------------------------------------------------
    // instruction cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            seq_reg   <= SEQ_IDLE;
            phase_reg <= 2'h0;
            EXEC_BUSY <= 1'b0;
            CYCLE_END <= 1'b0;
        end else begin
            CYCLE_END <= 1'b0;
            unique case (seq_reg)
                SEQ_IDLE: begin
                    phase_reg <= 2'h0;
                    if (wr_instr) begin
                        seq_reg   <= SEQ_EXEC;
                        EXEC_BUSY <= 1'b1;
                    end
                end
                SEQ_EXEC, SEQ_SECOND: begin
                    phase_reg <= phase_reg + 2'h1;
                    if (phase_reg == IDC_PHASE_LAST) begin
                        CYCLE_END <= 1'b1;
                        // second cycle executes as a no operation
                        seq_reg   <= (seq_reg == SEQ_EXEC && DEC_OUT.two_cycle) ? SEQ_SECOND : SEQ_IDLE;
                        EXEC_BUSY <= seq_reg == SEQ_EXEC && DEC_OUT.two_cycle;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // timer prescaler clear
    // ------------------------------------------------------------
    assign tmr_write = DEC_OUT.writes_file
                     & (DEC_OUT.file_addr == ctrl_reg[IDC_CTRL_TMR_LSB +: 7])
                     & ctrl_reg[IDC_CTRL_PSA_BIT];

    // pulse at the end of the first cycle, when the write lands
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            PRESCALER_CLR <= 1'b0;
        end else begin
            PRESCALER_CLR <= (seq_reg == SEQ_EXEC) & (phase_reg == IDC_PHASE_LAST) & tmr_write;
        end
    end

endmodule

// ---- rtl/idc_pkg.sv ----
package idc_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] IDC_OFS_INSTR  = 8'h00;
    localparam logic [7:0] IDC_OFS_FILE   = 8'h04;
    localparam logic [7:0] IDC_OFS_PINS   = 8'h08;
    localparam logic [7:0] IDC_OFS_CTRL   = 8'h0c;
    localparam logic [7:0] IDC_OFS_DEC_A  = 8'h10;
    localparam logic [7:0] IDC_OFS_DEC_B  = 8'h14;
    localparam logic [7:0] IDC_OFS_STATUS = 8'h18;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int IDC_CTRL_TMR_LSB  = 0;
    localparam int IDC_CTRL_PORT_LSB = 8;
    localparam int IDC_CTRL_PSA_BIT  = 16;
    localparam int IDC_DECA_FILE_LSB = 8;
    localparam int IDC_DECA_DEST_BIT = 15;
    localparam int IDC_DECA_BIT_LSB  = 16;
    localparam int IDC_DECA_OP_LSB   = 24;
    localparam int IDC_DECB_FLG_LSB  = 16;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [13:0] IDC_INSTR_RST = 14'h0000;
    localparam logic [7:0]  IDC_BYTE_RST  = 8'h00;
    localparam logic [16:0] IDC_CTRL_RST  = 17'h00000;
    localparam int          IDC_OSC_PER_CYCLE = 4;
    localparam logic [1:0]  IDC_PHASE_LAST = 2'(IDC_OSC_PER_CYCLE - 1);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        OP_NO_OPERATION, OP_ADD_ACC_FILE, OP_SUBTRACT_ACC_FROM_FILE, OP_AND_ACC_FILE,
        OP_OR_ACC_FILE, OP_XOR_ACC_FILE, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
        OP_COMPLEMENT_FILE, OP_DECREMENT_FILE, OP_INCREMENT_FILE, OP_MOVE_FILE,
        OP_SWAP_NIBBLES, OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO, OP_CLEAR_FILE,
        OP_CLEAR_ACC, OP_STORE_ACC_TO_FILE, OP_BIT_CLEAR, OP_BIT_SET,
        OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET, OP_LOAD_LITERAL, OP_OR_LITERAL,
        OP_AND_LITERAL, OP_XOR_LITERAL, OP_ADD_LITERAL, OP_LITERAL_MINUS_ACC,
        OP_RETURN_WITH_LITERAL, OP_CALL, OP_JUMP, OP_RETURN,
        OP_INTERRUPT_RETURN, OP_STANDBY, OP_WATCHDOG_CLEAR
    } idc_op_t;

    typedef struct packed {
        idc_op_t     op;
        logic        dest_file;
        logic [6:0]  file_addr;
        logic [2:0]  bit_num;
        logic [7:0]  literal;
        logic [10:0] target;
        logic        flag_c;
        logic        flag_dc;
        logic        flag_z;
        logic        flag_topd;
        logic        two_cycle;
        logic        skip;
        logic        file_read;
        logic        use_pins;
        logic        writes_file;
    } idc_dec_t;

    typedef enum logic [1:0] {
        SEQ_IDLE, SEQ_EXEC, SEQ_SECOND
    } idc_seq_t;

endpackage

// ---- verif/idc_decoder_monitor.sv ----
`timescale 1ns/1ps
module idc_decoder_monitor
    import idc_pkg::*;
(
    // clock, reset, bus
    input wire logic        CLK_SYS,
    input wire logic        RESET,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // decode side
    input wire idc_dec_t    DEC_OUT,
    input wire logic        EXEC_BUSY,
    input wire logic        CYCLE_END,
    input wire logic        PRESCALER_CLR
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    // ----------------------------------------
    // bus and sequencing
    // ----------------------------------------
    chk_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
    chk_rdata_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data without ack");
    chk_cycle_four:
        assert property ($rose(EXEC_BUSY) |-> !CYCLE_END [*4] ##1 CYCLE_END) else $error("cycle length");
    chk_one_cycle:
        assert property ($rose(EXEC_BUSY) && !DEC_OUT.two_cycle |-> EXEC_BUSY [*4] ##1 !EXEC_BUSY) else $error("one");
    chk_two_cycle:
        assert property ($rose(EXEC_BUSY) && DEC_OUT.two_cycle |-> EXEC_BUSY [*8] ##1 !EXEC_BUSY) else $error("two");
    chk_branch_two:
        assert property (EXEC_BUSY && DEC_OUT.op inside {OP_CALL, OP_JUMP, OP_RETURN, OP_INTERRUPT_RETURN,
            OP_RETURN_WITH_LITERAL} |-> DEC_OUT.two_cycle) else $error("branch length");
    chk_skip_two: assert property (EXEC_BUSY && DEC_OUT.skip |-> DEC_OUT.two_cycle) else $error("skip");
    chk_no_flags:
        assert property (EXEC_BUSY && DEC_OUT.op inside {OP_BIT_SET, OP_BIT_CLEAR, OP_SWAP_NIBBLES, OP_STORE_ACC_TO_FILE}
            |-> {DEC_OUT.flag_c, DEC_OUT.flag_dc, DEC_OUT.flag_z, DEC_OUT.flag_topd} == 4'h0) else $error("flags");
    chk_prescaler_end:
        assert property (PRESCALER_CLR |-> CYCLE_END && $past(EXEC_BUSY) && DEC_OUT.writes_file) else $error("psc");
    cover property ($rose(EXEC_BUSY) && DEC_OUT.two_cycle);
    cover property ($rose(EXEC_BUSY) && DEC_OUT.skip);
    cover property (PRESCALER_CLR);
endmodule
bind idc_decoder idc_decoder_monitor mon_u (.CLK_SYS(CLK_SYS), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .DEC_OUT(DEC_OUT), .EXEC_BUSY(EXEC_BUSY),
    .CYCLE_END(CYCLE_END), .PRESCALER_CLR(PRESCALER_CLR));

// ---- verif/idc_decoder_tb.sv ----
`timescale 1ns/1ps
module idc_decoder_tb
    import idc_pkg::*;
;
    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        busy;
    logic        cend;
    logic        pclr;
    idc_dec_t    dec;
    logic [5:0]  pc;
    logic [13:0] word;
    int          n_errors;
    int          check_count;
    int          n_cyc;
    int          n_ce;
    int          n_pc;
    idc_op_t     sk [4] = '{OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO, OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET};
    idc_decoder dut_u (.CLK_SYS(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .DEC_OUT(dec), .EXEC_BUSY(busy),
        .CYCLE_END(cend), .PRESCALER_CLR(pclr));
    idc_prog_mem mem_u (.ADDR(pc), .WORD(word));
    // ----------------------------------------
    // clock, timeout, shared tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        n_cyc++;
        if (n_cyc == 3000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    // fetch a word, issue it, count cycle ends and prescaler pulses until idle
    task automatic run(input logic [5:0] i, input idc_op_t op, input logic [3:0] f, input int cy, input int ep);
        pc <= i;
        @(posedge clk);
        wb(1'b1, IDC_OFS_INSTR, {18'h0, word});
        n_ce = 0;
        n_pc = 0;
        do begin
            @(posedge clk);
            n_ce += cend;
            n_pc += pclr;
        end while (busy !== 1'b0);
        chk(dec.op, op);
        chk({dec.flag_c, dec.flag_dc, dec.flag_z, dec.flag_topd}, f);
        chk(n_ce, cy);
        chk(n_pc, ep);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        wb(1'b0, IDC_OFS_CTRL, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 8'h40, 32'hffff_ffff);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_byte();
        run(0, OP_ADD_ACC_FILE, 4'he, 1, 0);
        chk({dec.dest_file, dec.file_addr, dec.file_read}, 9'h10b);
        run(1, OP_SUBTRACT_ACC_FROM_FILE, 4'he, 1, 0);
        run(2, OP_AND_ACC_FILE, 4'h2, 1, 0);
        run(3, OP_OR_ACC_FILE, 4'h2, 1, 0);
        run(4, OP_XOR_ACC_FILE, 4'h2, 1, 0);
        run(5, OP_ROTATE_LEFT_CARRY, 4'h8, 1, 0);
        run(6, OP_ROTATE_RIGHT_CARRY, 4'h8, 1, 0);
        run(7, OP_COMPLEMENT_FILE, 4'h2, 1, 0);
        run(8, OP_DECREMENT_FILE, 4'h2, 1, 0);
        run(9, OP_INCREMENT_FILE, 4'h2, 1, 0);
        run(10, OP_MOVE_FILE, 4'h2, 1, 0);
        run(11, OP_SWAP_NIBBLES, 4'h0, 1, 0);
        run(12, OP_CLEAR_FILE, 4'h2, 1, 0);
        run(13, OP_CLEAR_ACC, 4'h2, 1, 0);
        run(14, OP_STORE_ACC_TO_FILE, 4'h0, 1, 0);
        run(15, OP_NO_OPERATION, 4'h0, 1, 0);
        run(16, OP_BIT_CLEAR, 4'h0, 1, 0);
        chk({dec.bit_num, dec.file_addr}, 10'h185);
        run(17, OP_BIT_SET, 4'h0, 1, 0);
    endtask
    task automatic t_lit();
        run(18, OP_LOAD_LITERAL, 4'h0, 1, 0);
        chk(dec.literal, 8'haa);
        run(19, OP_OR_LITERAL, 4'h2, 1, 0);
        run(20, OP_AND_LITERAL, 4'h2, 1, 0);
        run(21, OP_XOR_LITERAL, 4'h2, 1, 0);
        run(22, OP_ADD_LITERAL, 4'he, 1, 0);
        run(23, OP_LITERAL_MINUS_ACC, 4'he, 1, 0);
        run(24, OP_RETURN_WITH_LITERAL, 4'h0, 2, 0);
        run(25, OP_CALL, 4'h0, 2, 0);
        chk(dec.target, 11'h123);
        wb(1'b0, IDC_OFS_DEC_B, 32'h0);
        chk(q, 32'h0010_0123);
        run(26, OP_JUMP, 4'h0, 2, 0);
        run(27, OP_RETURN, 4'h0, 2, 0);
        run(28, OP_INTERRUPT_RETURN, 4'h0, 2, 0);
        run(29, OP_STANDBY, 4'h1, 1, 0);
        run(30, OP_WATCHDOG_CLEAR, 4'h1, 1, 0);
        run(31, OP_NO_OPERATION, 4'h0, 1, 0);
    endtask
    task automatic t_skip(input logic [31:0] ctl, input logic [7:0] fv, input logic [7:0] pv, input logic [3:0] tk);
        wb(1'b1, IDC_OFS_CTRL, ctl);
        wb(1'b1, IDC_OFS_FILE, {24'h0, fv});
        wb(1'b1, IDC_OFS_PINS, {24'h0, pv});
        for (int i = 0; i < 4; i++) begin
            run(6'(32 + i), sk[i], 4'h0, tk[i] ? 2 : 1, 0);
        end
        chk(dec.use_pins, ctl[14:8] == 7'h05);
    endtask
    task automatic t_psc();
        wb(1'b1, IDC_OFS_CTRL, 32'h10005);
        run(14, OP_STORE_ACC_TO_FILE, 4'h0, 1, 1);
        run(36, OP_MOVE_FILE, 4'h2, 1, 0);
        wb(1'b1, IDC_OFS_CTRL, 32'h00005);
        run(14, OP_STORE_ACC_TO_FILE, 4'h0, 1, 0);
    endtask
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        pc = 6'h00;
        n_errors = 0;
        check_count = 0;
        n_cyc = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_byte();
        t_lit();
        t_skip(32'h0, 8'h01, 8'h00, 4'b0101);
        t_skip(32'h0, 8'hff, 8'h00, 4'b1010);
        t_skip(32'h500, 8'hff, 8'h01, 4'b0101);
        t_psc();
        finish_test();
    end
endmodule

// ---- verif/idc_prog_mem.sv ----
`timescale 1ns/1ps
module idc_prog_mem (
    // fetch port
    input  wire logic [5:0]  ADDR,
    output logic      [13:0] WORD
);
    // ----------------------------------------
    // program words: byte, bit, literal, skips
    // ----------------------------------------
    logic [13:0] rom [37] = '{
        14'h0785, 14'h0285, 14'h0585, 14'h0485, 14'h0685, 14'h0d85, 14'h0c85, 14'h0985, 14'h0385, 14'h0a85,
        14'h0885, 14'h0e85, 14'h0185, 14'h0105, 14'h0085, 14'h0060, 14'h1185, 14'h1585, 14'h33aa, 14'h38aa,
        14'h39aa, 14'h3aaa, 14'h3faa, 14'h3daa, 14'h37aa, 14'h2123, 14'h2923, 14'h0008, 14'h0009, 14'h0063,
        14'h0064, 14'h3baa, 14'h0b85, 14'h0f85, 14'h1985, 14'h1d85, 14'h0805};
    // past the table the word is the inverted address: a changing pattern, never a stale word
    assign WORD = (ADDR < 6'd37) ? rom[ADDR] : ~{8'h0, ADDR};
endmodule
